// >>> logic/johnson_decade_consts.svh
// Constants for the Johnson decade counter: widths, reset values
`ifndef JOHNSON_DECADE_CONSTS_SVH
`define JOHNSON_DECADE_CONSTS_SVH
`define RING_W        5
`define DEC_W         10
`define RING_RST      5'h00
`define DEC_RST       10'h001
`define UPPER_N_RST   1'b1
`define FILT_SHIFT_W  3
`define FILT_SH_RST   3'h0
`endif

// >>> logic/johnson_decade_pkg.sv
// State types for the Johnson decade counter and its pin filter
`include "johnson_decade_consts.svh"
package johnson_decade_pkg;
   // Pin filter state: three-stage shift plus accepted level
   typedef struct packed {
      logic [`FILT_SHIFT_W-1:0] sh;
      logic                     lvl;
   } pin_filt_t;
   // Counter state: ring, edge history, registered outputs
   typedef struct packed {
      logic [`RING_W-1:0] ring;
      logic               rise_prev;
      logic               inh_prev;
      logic [`DEC_W-1:0]  dec;
      logic               upper_n;
   } johnson_t;
endpackage

// >>> logic/pin_filter.sv
// Three-flop pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`include "johnson_decade_consts.svh"
module pin_filter
   import johnson_decade_pkg::*;
(
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic pin,
   output logic      level
);
   pin_filt_t st_ff;   // Registered state
   pin_filt_t nxt_st;  // Next state

   // Shift the pin in; update level when stages two and three agree
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.sh = {st_ff.sh[1:0], pin};
      if (st_ff.sh[1] == st_ff.sh[2]) begin
         nxt_st.lvl = st_ff.sh[2];
      end
      if (!rstn) begin
         nxt_st.sh  = `FILT_SH_RST;
         nxt_st.lvl = 1'b0;
      end
   end

   // Register the state
   always_ff @(posedge clock) begin
      st_ff <= nxt_st;
   end

   assign level = st_ff.lvl;
endmodule

// >>> logic/johnson_decade_counter.sv
// Five-stage Johnson decade counter with ten decoded outputs
//
// How it works
// RQ1: Five-stage twisted ring, ten states, divide by ten
// RQ2: Ten one-hot decoded outputs, glitch free
// RQ3: Active-low output low in states five to nine
// RQ4: Clear shows state zero and upper output high
// RQ5: Advance on rising edge or falling inhibit edge
// RQ6: Hold on all other clock conditions
// RQ7: Clear acts at once, overrides counting
// RQ8: Decoded output steps n to n+1, wraps
`timescale 1ns/1ps
`include "johnson_decade_consts.svh"
module johnson_decade_counter
   import johnson_decade_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic              count_clock_rising,
   input  wire logic              count_clock_falling_inhibit,
   input  wire logic              async_clear_in,
   output logic [`DEC_W-1:0]      decoded_state_outputs,
   output logic                   upper_half_low_output
);
   johnson_t           st_ff;     // Registered state
   johnson_t           nxt_st;    // Next state
   logic               rise_lvl;  // Filtered rising clock level
   logic               inh_lvl;   // Filtered inhibit clock level
   logic               clr_lvl;   // Filtered clear level
   logic               adv;       // One advance this cycle
   logic [`RING_W-1:0] nxt_ring;  // Ring after this cycle
   logic [`DEC_W-1:0]  nxt_dec;   // Decode of next ring

   // Pin filters for the three outside inputs. Each pin passes three
   // flops and its level is taken only when the last two agree, so a
   // pin edge reaches the counting logic four clocks late and a pulse
   // shorter than about two clocks may be lost
   pin_filter u_rise (
      .clock (clock),
      .rstn  (rstn),
      .pin   (count_clock_rising),
      .level (rise_lvl)
   );
   pin_filter u_inh (
      .clock (clock),
      .rstn  (rstn),
      .pin   (count_clock_falling_inhibit),
      .level (inh_lvl)
   );
   pin_filter u_clr (
      .clock (clock),
      .rstn  (rstn),
      .pin   (async_clear_in),
      .level (clr_lvl)
   );

   // Advance condition from the two clock inputs. Both edge kinds are
   // seen against last cycle's filtered levels; should both appear in
   // one cycle they still give a single advance
   always_comb begin
      adv = (rise_lvl & ~st_ff.rise_prev & ~inh_lvl)   // RQ5
          | (~inh_lvl & st_ff.inh_prev & rise_lvl);    // RQ5
   end

   // Next ring: shift in inverted top stage on advance, clear wins.
   // The filtered clear holds the ring at zero while it stands, so
   // edges seen during a clear are dropped, not stored
   always_comb begin
      nxt_ring = st_ff.ring;                           // RQ6
      if (clr_lvl || !rstn) begin
         nxt_ring = `RING_RST;                         // RQ7
      end else if (adv) begin
         nxt_ring = {st_ff.ring[3:0], ~st_ff.ring[4]}; // RQ1
      end
   end

   // Two-bit decode of each state, one per output. Every output looks
   // at just two adjacent stages, and only one stage moves per advance,
   // so no output can pulse while the ring steps
   genvar k;
   generate
      for (k = 0; k < `DEC_W; k++) begin : g_dec
         if (k == 0) begin : g_z
            assign nxt_dec[k] = ~nxt_ring[0] & ~nxt_ring[4]; // RQ2
         end else if (k < 5) begin : g_lo
            assign nxt_dec[k] = nxt_ring[k-1] & ~nxt_ring[k]; // RQ2
         end else if (k == 5) begin : g_f
            assign nxt_dec[k] = nxt_ring[4] & nxt_ring[0];    // RQ2
         end else begin : g_hi
            assign nxt_dec[k] = ~nxt_ring[k-6] & nxt_ring[k-5]; // RQ2
         end
      end
   endgenerate

   // Fill next state; outputs registered from next ring. Decoding the
   // next ring rather than the current one keeps the outputs in step
   // with the ring instead of one clock behind it
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.ring      = nxt_ring;
      nxt_st.rise_prev = rise_lvl;
      nxt_st.inh_prev  = inh_lvl;
      nxt_st.dec       = nxt_dec;                 // RQ8
      nxt_st.upper_n   = ~nxt_ring[4];            // RQ3
      if (!rstn) begin
         nxt_st.rise_prev = 1'b0;
         nxt_st.inh_prev  = 1'b0;
         nxt_st.dec       = `DEC_RST;
         nxt_st.upper_n   = `UPPER_N_RST;
      end
   end

   // Register the state
   always_ff @(posedge clock) begin
      st_ff <= nxt_st;
   end

   // Raw clear forces the outputs at once, without a clock edge. This
   // path bypasses the filter on purpose; the ring itself follows a few
   // clocks later through the filtered clear
   always_comb begin
      if (async_clear_in) begin
         decoded_state_outputs = `DEC_RST;        // RQ4
         upper_half_low_output = `UPPER_N_RST;    // RQ4
      end else begin
         decoded_state_outputs = st_ff.dec;
         upper_half_low_output = st_ff.upper_n;
      end
   end

   // Every property below runs on the system clock and is muted while
   // the synchronous reset is held, when filters and edge history are
   // being flushed and carry no meaning
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // Registered decode stays one-hot in every state
   a_dec_one_hot: assert property ( // RQ2
      $onehot(st_ff.dec))
      else $error("decoded outputs not one-hot");

   // Ring only holds one of the ten twisted-ring codes; a legal code
   // differs from its successor in exactly one stage
   a_ring_legal: assert property ( // RQ1
      $countones(st_ff.ring ^ {st_ff.ring[3:0], ~st_ff.ring[4]}) == 1)
      else $error("ring left the ten-state sequence");

   // Upper output low exactly in states five to nine
   a_upper_half: assert property ( // RQ3
      st_ff.upper_n == ~(|st_ff.dec[9:5]))
      else $error("upper output disagrees with decode");

   // Same relation on the pins while no clear forces them
   a_upper_pin: assert property ( // RQ3
      !async_clear_in |->
      upper_half_low_output == ~(|decoded_state_outputs[9:5]))
      else $error("upper pin disagrees with decoded pins");

   // Raw clear forces the zero pattern on the pins
   a_clear_pins: assert property ( // RQ4
      async_clear_in |->
      decoded_state_outputs == `DEC_RST && upper_half_low_output)
      else $error("clear pattern not shown");

   // Filtered clear resets the ring, even with an advance
   a_clear_ring: assert property ( // RQ7
      clr_lvl |=> st_ff.ring == `RING_RST)
      else $error("ring not cleared");

   // A clear that has stood two edges keeps the zero decode
   a_clear_held: assert property ( // RQ7
      clr_lvl && $past(clr_lvl) |-> st_ff.dec == `DEC_RST)
      else $error("decode moved while clear held");

   // Advance shifts the twisted ring by one stage
   a_ring_shift: assert property ( // RQ1
      adv && !clr_lvl |=>
      st_ff.ring == {$past(st_ff.ring[3:0]), ~$past(st_ff.ring[4])})
      else $error("ring did not shift");

   // No advance, no change
   a_ring_hold: assert property ( // RQ6
      !adv && !clr_lvl |=> $stable(st_ff.ring))
      else $error("ring changed without advance");

   // A high inhibit level blocks both ways of counting
   a_inh_blocks: assert property ( // RQ6
      inh_lvl && !clr_lvl |=> $stable(st_ff.ring))
      else $error("ring moved with inhibit high");

   // A low rising-clock level blocks both ways of counting
   a_rise_low_hold: assert property ( // RQ6
      !rise_lvl && !clr_lvl |=> $stable(st_ff.ring))
      else $error("ring moved with rising clock low");

   // Decoded output steps by one place
   a_dec_step: assert property ( // RQ8
      adv && !clr_lvl && !st_ff.dec[9] |=>
      st_ff.dec == {$past(st_ff.dec[8:0]), 1'b0})
      else $error("decode did not step");

   // Wrap from state nine to zero
   a_dec_wrap: assert property ( // RQ8
      adv && !clr_lvl && st_ff.dec[9] |=> st_ff.dec[0])
      else $error("decode did not wrap");

   // Rising edge with inhibit low counts; paired with the step check
   // below so a broken edge term shows in the decode as well
   a_rise_adv: assert property ( // RQ5
      rise_lvl && !st_ff.rise_prev && !inh_lvl |-> adv)
      else $error("rising edge not counted");

   // The counted rising edge really moves the registered decode
   a_rise_step: assert property ( // RQ5
      rise_lvl && !st_ff.rise_prev && !inh_lvl && !clr_lvl |=>
      !$stable(st_ff.dec))
      else $error("rising edge left decode unchanged");

   // Falling inhibit edge with the rising clock high counts too
   a_fall_step: assert property ( // RQ5
      !inh_lvl && st_ff.inh_prev && rise_lvl && !clr_lvl |=>
      !$stable(st_ff.dec))
      else $error("falling inhibit edge left decode unchanged");
endmodule

// >>> verif/pin_driver.sv
// Model of the surrounding logic that drives the counter pins
`timescale 1ns/1ps
module pin_driver (
   input  wire logic clock,
   output logic      rise_pin,
   output logic      inh_pin,
   output logic      clr_pin
);
   // All pins start low
   initial begin
      rise_pin = 1'b0;
      inh_pin  = 1'b0;
      clr_pin  = 1'b0;
   end
   // Set pins after an edge, then hold long enough for the filter
   task automatic apply(input logic r, input logic i, input logic c);
      @(posedge clock);
      rise_pin <= r;
      inh_pin  <= i;
      clr_pin  <= c;
      repeat (8) @(posedge clock);
   endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the Johnson decade counter
`timescale 1ns/1ps
`include "johnson_decade_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
 $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench import johnson_decade_pkg::*; ();
   logic              clock;
   logic              rstn;
   logic              rise_pin, inh_pin, clr_pin;
   logic [`DEC_W-1:0] dec;
   logic              upper_n;
   int                n_errors = 0;
   int                check_count = 0;
   int                cnt = 0;
   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   pin_driver u_pin_driver (.clock(clock), .rise_pin(rise_pin),
      .inh_pin(inh_pin), .clr_pin(clr_pin));
   johnson_decade_counter u_johnson_decade_counter (.clock(clock),
      .rstn(rstn), .count_clock_rising(rise_pin),
      .count_clock_falling_inhibit(inh_pin), .async_clear_in(clr_pin),
      .decoded_state_outputs(dec), .upper_half_low_output(upper_n));
   // Compare outputs with the tracked state
   task automatic expect_state();
      `CHK(dec, 10'h001 << cnt)
      `CHK(upper_n, cnt < 5)
   endtask
   // Rising-clock edges step through more than one full ring
   task automatic t_rise();
      for (int k = 0; k < 12; k++) begin
         u_pin_driver.apply(1'b1, 1'b0, 1'b0);
         cnt = (cnt + 1) % 10;
         expect_state();
         u_pin_driver.apply(1'b0, 1'b0, 1'b0);
         expect_state();
      end
      $display("t_rise done");
   endtask
   // Inhibit-pin edges against a held rising-clock level
   task automatic t_fall();
      logic [5:0] r;
      logic [5:0] i;
      logic [5:0] a;
      r = 6'h1e;
      i = 6'h0b;
      a = 6'h14;
      for (int k = 0; k < 6; k++) begin
         u_pin_driver.apply(r[k], i[k], 1'b0);
         if (a[k]) cnt = (cnt + 1) % 10;
         expect_state();
      end
      $display("t_fall done");
   endtask
   // Clear acts with no clock edge and beats counting
   task automatic t_clear();
      cnt = 0;
      fork
         u_pin_driver.apply(1'b0, 1'b0, 1'b1);
         begin
            @(posedge clock);
            #1;
            expect_state();
         end
      join
      u_pin_driver.apply(1'b1, 1'b0, 1'b1);
      expect_state();
      u_pin_driver.apply(1'b0, 1'b0, 1'b0);
      expect_state();
      u_pin_driver.apply(1'b1, 1'b0, 1'b0);
      cnt = 1;
      expect_state();
      $display("t_clear done");
   endtask
   // Print counts and verdict, then stop
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      #50000;
      n_errors++;
      conclude();
   end
   // Reset for 20 cycles, then run the tests
   initial begin
      rstn = 1'b0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      repeat (4) @(posedge clock);
      expect_state();
      t_rise();
      t_fall();
      t_clear();
      conclude();
   end
endmodule
